// file: hdl/synth_serial_load_lock_power.sv
// serial load port, reference configuration latch, lock detect,
// multifunction and auxiliary outputs, and power-down gating.
// assumes pins are asynchronous to clk_i and the serial clock is slow
// enough (well above 3 system clocks per phase) to be edge-sampled.
// the power-down bit arrives on clk_i from the feedback register latch.
// lock thresholds round to whole system clock periods.
// Function
// [RQ1] shift serial data on each serial clock rise
// [RQ2] words arrive most significant bit first
// [RQ3] upper 22 bits data, low two address
// [RQ4] load strobe rise copies data into one latch
// [RQ5] address 10 writes reference divider configuration
// [RQ6] data bits 14..0 are reference divide ratio
// [RQ7] host keeps divide ratio within 3..32767
// [RQ8] data bit 20 enables charge pump doubler
// [RQ9] data bit 21 selects fast calibration
// [RQ10] bits 15..19 polarity and four current weights
// [RQ11] lock after five cycles under 15 ns
// [RQ12] unlock at once when error exceeds 30 ns
// [RQ13] analog lock high while pump is inactive
// [RQ14] lock indication low while powered down
// [RQ15] multifunction output selects lock or divider outputs
// [RQ16] mode field sets aux outputs, test overrides
// [RQ17] fast acquisition raises current, pulls aux0 low
// [RQ18] enable pin low forces power-down except doubler
// [RQ19] power-down stops counters, tristates pump and comparator
// [RQ20] oscillator input off in power-down unless doubler
// [RQ21] power-down resets counters, realigned restart
// [RQ22] serial port keeps working while powered down
// [RQ23] current weights give 100 to 1600 microamps
// [RQ24] host sets polarity to match oscillator slope
// [RQ25] host holds strobe low while shifting 24 bits
// [RQ26] settings change only on load strobe rise
`timescale 1ns/1ps
`default_nettype none
module synth_serial_load_lock_power
  import synth_pkg::*;
#(
  parameter int LOCK_CYCLES = synth_pkg::LOCK_CONSEC // good cycles before lock
) (
  input wire logic clk_i, // 20 MHz system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic serial_clk_i, // serial clock pin
  input wire logic serial_data_i, // serial data pin
  input wire logic load_strobe_i, // load strobe pin
  input wire logic enable_i, // chip enable pin, low powers down
  input wire logic power_down_bit_i, // power-down bit from feedback register
  input wire logic ref_div_out_i, // reference divider output
  input wire logic fb_div_out_i, // feedback divider output
  input wire logic pump_active_i, // phase detector pump activity
  output logic [synth_pkg::REF_RATIO_W-1:0] reference_divide_ratio_o, // reference ratio
  output logic detector_polarity_o, // swaps pump up and down sense
  output logic pump_weight_one_o, // current weight 1x
  output logic pump_weight_two_o, // current weight 2x
  output logic pump_weight_four_o, // current weight 4x
  output logic pump_weight_eight_o, // current weight 8x
  output logic [synth_pkg::PUMP_UA_W-1:0] pump_current_ua_o, // pump current in uA
  output logic doubler_enable_o, // charge pump voltage doubler on
  output logic dll_fast_o, // fast delay-line calibration
  output logic counters_enable_o, // reference and feedback counters run
  output logic counter_reset_o, // reset both counters together
  output logic pump_hiz_o, // pump and comparator high impedance
  output logic osc_input_enable_o, // reference oscillator input biased
  output logic multifunction_lock_output_o, // multiplexed lock/divider pin
  output logic aux_out0_o, // auxiliary output 0 level
  output logic aux_out0_oe_o, // auxiliary output 0 drive enable
  output logic aux_out1_o, // auxiliary output 1 level
  output logic n_load_o, // pulse: word for feedback register
  output logic [synth_pkg::DATA_W-1:0] load_data_o // data field of last load
);
  import synth_pkg::*;

  // bit positions inside the synchroniser bank
  localparam int NPIN = 7;
  localparam int P_SCLK = 0;
  localparam int P_SDATA = 1;
  localparam int P_LOAD = 2;
  localparam int P_EN = 3;
  localparam int P_REF = 4;
  localparam int P_FB = 5;
  localparam int P_PUMP = 6;

  // synchronised pins, latched settings and lock filter state
  logic [NPIN-1:0] pin_level;
  logic [NPIN-1:0] pin_rise;
  logic [SR_W-1:0] shift_reg;
  logic [DATA_W-1:0] data_field;
  logic [ADDR_W-1:0] addr_field;
  logic [DATA_W-1:0] ref_cfg;
  logic [SEL_W-1:0] multifunction_lock_output_sel;
  logic [MODE_W-1:0] aux_mode;
  logic powered_down;
  logic [ERR_CNT_W-1:0] err_cnt;
  logic [GOOD_CNT_W-1:0] good_cnt;
  logic digital_lock;
  logic analog_lock;
  logic fast_acq;
  logic [WEIGHT_W-1:0] weight_eff;
  logic next_multifunction_lock_output;
  logic load_f1, load_f2, load_ref, load_n;

  // elaboration-time guards: a bad split or a narrow counter fails the build
  if (DATA_W + ADDR_W != SR_W) begin : g_split_bad
    $error("shift register split does not add up");
  end
  if (LOCK_CYCLES < 1 || LOCK_CYCLES >= (1 << GOOD_CNT_W)) begin : g_good_bad
    $error("lock cycle count does not fit the good counter");
  end
  if (UNLOCK_ERR_CYC + 1 >= (1 << ERR_CNT_W)) begin : g_err_bad
    $error("error counter too narrow");
  end

  // all pins pass three flops; data is delayed alike so it pairs with the clock edge
  pin_sync #(
    .WIDTH(NPIN)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({pump_active_i, fb_div_out_i, ref_div_out_i, enable_i,
            load_strobe_i, serial_data_i, serial_clk_i}),
    .level_o(pin_level),
    .rise_o(pin_rise)
  );

  // split of the shift register into data and address fields
  assign data_field = shift_reg[SR_W-1:DATA_LSB]; // RQ3
  assign addr_field = shift_reg[ADDR_W-1:0]; // RQ3

  // one strobe rise fires exactly one of the four latch selects
  assign load_f1 = pin_rise[P_LOAD] && addr_field == ADDR_F1; // RQ4
  assign load_f2 = pin_rise[P_LOAD] && addr_field == ADDR_F2; // RQ4
  assign load_ref = pin_rise[P_LOAD] && addr_field == ADDR_REF; // RQ4 RQ5
  assign load_n = pin_rise[P_LOAD] && addr_field == ADDR_N; // RQ4

  // serial shift register; runs regardless of any power-down state
  // extra bits push the oldest out; the last 24 shifted count
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_reg <= '0;
    end else if (pin_rise[P_SCLK]) begin // RQ1 RQ22
      shift_reg <= {shift_reg[SR_W-2:0], pin_level[P_SDATA]}; // RQ2
    end
  end

  // reference configuration latch, written only on a strobe rise
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_cfg <= REF_RESET;
    end else if (load_ref) begin // RQ4 RQ5 RQ26
      ref_cfg <= data_field;
    end
  end

  // multifunction select latch
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      multifunction_lock_output_sel <= F1_SEL_RESET;
    end else if (load_f1) begin // RQ4 RQ26
      multifunction_lock_output_sel <= data_field[F1_SEL_LSB +: SEL_W];
    end
  end

  // auxiliary output mode latch
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aux_mode <= F2_MODE_RESET;
    end else if (load_f2) begin // RQ4 RQ26
      aux_mode <= data_field[F2_MODE_LSB +: MODE_W];
    end
  end

  // feedback register word is handed out; that latch lives elsewhere
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      n_load_o <= 1'b0;
    end else begin
      n_load_o <= load_n; // RQ4
    end
  end

  // data field of every load, whatever its address
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      load_data_o <= '0;
    end else if (pin_rise[P_LOAD]) begin
      load_data_o <= data_field;
    end
  end

  // a low pin wins over the bit; with the pin high the bit decides
  assign powered_down = !pin_level[P_EN] || power_down_bit_i; // RQ18

  // phase error width per comparison cycle, counted in system clocks.
  // resolution is one clock, so the thresholds round to whole cycles.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_cnt <= '0;
    end else if (pin_rise[P_REF]) begin
      err_cnt <= {{(ERR_CNT_W-1){1'b0}}, pin_level[P_PUMP]};
    end else if (pin_level[P_PUMP] && err_cnt != {ERR_CNT_W{1'b1}}) begin
      err_cnt <= err_cnt + 1'b1;
    end
  end

  // digital lock filter: consecutive good cycles set, one bad cycle clears
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      good_cnt <= '0;
      digital_lock <= 1'b0;
    end else if (powered_down) begin
      good_cnt <= '0; // RQ14
      digital_lock <= 1'b0; // RQ14
    end else if (pin_rise[P_REF]) begin
      if (32'(err_cnt) > UNLOCK_ERR_CYC) begin
        good_cnt <= '0;
        digital_lock <= 1'b0; // RQ12
      end else if (32'(err_cnt) < LOCK_ERR_CYC) begin
        if (32'(good_cnt) < LOCK_CYCLES) begin
          good_cnt <= good_cnt + 1'b1;
        end
        if (32'(good_cnt) + 1 >= LOCK_CYCLES) begin
          digital_lock <= 1'b1; // RQ11
        end
      end else begin
        good_cnt <= '0; // RQ11
      end
    end else if (pin_level[P_PUMP] && 32'(err_cnt) >= UNLOCK_ERR_CYC) begin
      // error passes the limit inside this cycle: drop lock now,
      // not at the next comparison edge, so a slip shows at once
      good_cnt <= '0;
      digital_lock <= 1'b0; // RQ12
    end
  end

  // analog lock follows pump inactivity, forced low while powered down
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      analog_lock <= 1'b0;
    end else begin
      analog_lock <= !powered_down && !pin_level[P_PUMP]; // RQ13 RQ14
    end
  end

  // multifunction output mux
  // select codes 4 to 7 are unassigned and hold the pin low
  always_comb begin
    unique case (multifunction_lock_output_sel)
      SEL_DIGITAL: next_multifunction_lock_output = digital_lock; // RQ15
      SEL_ANALOG: next_multifunction_lock_output = analog_lock; // RQ15
      SEL_REF_DIV: next_multifunction_lock_output = pin_level[P_REF]; // RQ15
      SEL_FB_DIV: next_multifunction_lock_output = pin_level[P_FB]; // RQ15
      default: next_multifunction_lock_output = 1'b0;
    endcase
  end

  // registered so a select change never glitches the pin
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      multifunction_lock_output_o <= 1'b0;
    end else begin
      multifunction_lock_output_o <= next_multifunction_lock_output;
    end
  end

  // fast acquisition lasts until the digital lock comes up
  assign fast_acq = aux_mode[MODE_FAST_BIT] && !aux_mode[MODE_TEST_BIT] && !digital_lock;
  assign weight_eff = fast_acq ? WEIGHT_MAX : ref_cfg[REF_WEIGHT_LSB +: WEIGHT_W]; // RQ17

  // auxiliary outputs: test mode overrides, else fast acquisition or plain logic
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aux_out0_o <= 1'b0;
      aux_out0_oe_o <= 1'b1;
      aux_out1_o <= 1'b0;
    end else if (aux_mode[MODE_TEST_BIT]) begin // RQ16
      aux_out0_o <= pin_level[P_REF];
      aux_out0_oe_o <= 1'b1;
      aux_out1_o <= pin_level[P_FB];
    end else if (aux_mode[MODE_FAST_BIT]) begin
      // released once locked, so the extra resistor floats again
      aux_out0_o <= 1'b0; // RQ17
      aux_out0_oe_o <= fast_acq; // RQ17
      aux_out1_o <= aux_mode[MODE_GP1_BIT];
    end else begin
      aux_out0_o <= aux_mode[MODE_GP0_BIT]; // RQ16
      aux_out0_oe_o <= 1'b1;
      aux_out1_o <= aux_mode[MODE_GP1_BIT]; // RQ16
    end
  end

  // configuration outputs decoded from the reference latch
  // the doubler bit ignores power-down so the pump supply stays up
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reference_divide_ratio_o <= '0;
      detector_polarity_o <= 1'b0;
      doubler_enable_o <= 1'b0;
      dll_fast_o <= 1'b0;
    end else begin
      reference_divide_ratio_o <= ref_cfg[REF_RATIO_LSB +: REF_RATIO_W]; // RQ6
      detector_polarity_o <= ref_cfg[REF_POL_BIT]; // RQ10
      doubler_enable_o <= ref_cfg[REF_DOUBLER_BIT]; // RQ8 RQ18
      dll_fast_o <= ref_cfg[REF_DLL_BIT]; // RQ9
    end
  end

  // pump weights and resulting current, 100 uA per code step
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pump_weight_one_o <= 1'b0;
      pump_weight_two_o <= 1'b0;
      pump_weight_four_o <= 1'b0;
      pump_weight_eight_o <= 1'b0;
      pump_current_ua_o <= PUMP_UA_W'(PUMP_STEP_UA);
    end else begin
      pump_weight_one_o <= weight_eff[0]; // RQ10
      pump_weight_two_o <= weight_eff[1]; // RQ10
      pump_weight_four_o <= weight_eff[2]; // RQ10
      pump_weight_eight_o <= weight_eff[3]; // RQ10
      pump_current_ua_o <= PUMP_UA_W'((32'(weight_eff) + 1) * PUMP_STEP_UA); // RQ23
    end
  end

  // power gating; one reset line releases both counters in the same cycle
  // so the feedback counter restarts aligned with the reference counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      counters_enable_o <= 1'b0;
      counter_reset_o <= 1'b1;
      pump_hiz_o <= 1'b1;
      osc_input_enable_o <= 1'b0;
    end else begin
      counters_enable_o <= !powered_down; // RQ19
      counter_reset_o <= powered_down; // RQ21
      pump_hiz_o <= powered_down; // RQ19
      osc_input_enable_o <= !powered_down || ref_cfg[REF_DOUBLER_BIT]; // RQ20
    end
  end

endmodule // synth_serial_load_lock_power
`default_nettype wire

// file: hdl/synth_pkg.sv
// constants for the synthesizer serial load, lock detect and power control
// assumes a single 20 MHz system clock domain for all internal logic
package synth_pkg;

  // shift register and field layout
  localparam int SR_W = 24;
  localparam int DATA_W = 22;
  localparam int ADDR_W = 2;
  localparam int DATA_LSB = 2;

  // latch address codes
  localparam logic [1:0] ADDR_F1 = 2'b00;
  localparam logic [1:0] ADDR_F2 = 2'b01;
  localparam logic [1:0] ADDR_REF = 2'b10;
  localparam logic [1:0] ADDR_N = 2'b11;

  // reference divider configuration fields (data bit positions)
  localparam int REF_RATIO_LSB = 0;
  localparam int REF_RATIO_W = 15;
  localparam int REF_POL_BIT = 15;
  localparam int REF_WEIGHT_LSB = 16;
  localparam int WEIGHT_W = 4;
  localparam int REF_DOUBLER_BIT = 20;
  localparam int REF_DLL_BIT = 21;
  localparam logic [21:0] REF_RESET = 22'h00_0000;

  // first auxiliary register: multifunction output select
  localparam int F1_SEL_LSB = 18;
  localparam int SEL_W = 3;
  localparam logic [2:0] F1_SEL_RESET = 3'h0;
  localparam logic [2:0] SEL_DIGITAL = 3'h0;
  localparam logic [2:0] SEL_ANALOG = 3'h1;
  localparam logic [2:0] SEL_REF_DIV = 3'h2;
  localparam logic [2:0] SEL_FB_DIV = 3'h3;

  // second auxiliary register: output mode field
  localparam int F2_MODE_LSB = 15;
  localparam int MODE_W = 4;
  localparam logic [3:0] F2_MODE_RESET = 4'h0;
  localparam int MODE_TEST_BIT = 3;
  localparam int MODE_FAST_BIT = 2;
  localparam int MODE_GP1_BIT = 1;
  localparam int MODE_GP0_BIT = 0;

  // pump current table: 100 uA per step above a 100 uA floor
  localparam int PUMP_STEP_UA = 100;
  localparam int PUMP_UA_W = 11;
  localparam logic [3:0] WEIGHT_MAX = 4'hF;

  // lock detect timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOCK_ERR_NS = 15;
  localparam int UNLOCK_ERR_NS = 30;
  localparam int LOCK_ERR_CYC_RAW = (LOCK_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_ERR_CYC = (LOCK_ERR_CYC_RAW < 1) ? 1 : LOCK_ERR_CYC_RAW;
  localparam int UNLOCK_ERR_CYC_RAW = UNLOCK_ERR_NS / CLK_PERIOD_NS;
  localparam int UNLOCK_ERR_CYC = (UNLOCK_ERR_CYC_RAW < 1) ? 1 : UNLOCK_ERR_CYC_RAW;
  localparam int LOCK_CONSEC = 5;
  localparam int ERR_CNT_W = 4;
  localparam int GOOD_CNT_W = 3;

endpackage

// file: hdl/pin_sync.sv
// two-flop synchroniser bank with rising-edge detect on the synced level
// assumes inputs are asynchronous pins; outputs are on clk_i
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic [WIDTH-1:0] pin_i, // asynchronous pins
  output logic [WIDTH-1:0] level_o, // synchronised level
  output logic [WIDTH-1:0] rise_o // one-cycle pulse on rising edge
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  // first flop feeds only the second, to keep metastability contained
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= pin_i;
      sync <= meta;
    end
  end

  // edge history and registered outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev <= '0;
      level_o <= '0;
      rise_o <= '0;
    end else begin
      prev <= sync;
      level_o <= sync;
      rise_o <= sync & ~prev;
    end
  end

endmodule // pin_sync
`default_nettype wire

// file: test/synth_checker.sv
// checker: port-level assertions for the synthesizer control block
// assumes it is bound into the design top; one clock domain
`timescale 1ns/1ps
`default_nettype none
module synth_checker
  import synth_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic load_strobe_i, // load strobe pin
  input wire logic enable_i, // chip enable pin
  input wire logic power_down_bit_i, // power-down bit
  input wire logic [synth_pkg::REF_RATIO_W-1:0] reference_divide_ratio_o, // ratio
  input wire logic detector_polarity_o, // polarity
  input wire logic pump_weight_one_o, // weight 1x
  input wire logic pump_weight_two_o, // weight 2x
  input wire logic pump_weight_four_o, // weight 4x
  input wire logic pump_weight_eight_o, // weight 8x
  input wire logic [synth_pkg::PUMP_UA_W-1:0] pump_current_ua_o, // current
  input wire logic doubler_enable_o, // doubler on
  input wire logic dll_fast_o, // calibration speed
  input wire logic counters_enable_o, // counters run
  input wire logic counter_reset_o, // counters held
  input wire logic pump_hiz_o, // pump tristated
  input wire logic osc_input_enable_o, // oscillator input on
  input wire logic n_load_o // feedback word pulse
);
  logic [3:0] pump_code;
  // weights as one code; fast acquisition may force it without a load
  assign pump_code = {pump_weight_eight_o, pump_weight_four_o, pump_weight_two_o, pump_weight_one_o};
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  pd_outputs_a: assert property (pump_hiz_o == counter_reset_o && counters_enable_o != counter_reset_o)
    else $error("pump tristate and counter gating disagree");
  osc_gate_a: assert property (osc_input_enable_o == (counters_enable_o | doubler_enable_o))
    else $error("oscillator input gating wrong");
  pin_down_a: assert property (!enable_i [*5] |-> counter_reset_o)
    else $error("low enable pin did not power down");
  bit_down_a: assert property (power_down_bit_i [*3] |-> counter_reset_o && !counters_enable_o)
    else $error("power-down bit did not stop counters");
  power_up_a: assert property ((enable_i && !power_down_bit_i) [*8] |-> counters_enable_o)
    else $error("counters not running while powered up");
  pump_current_a: assert property (32'(pump_current_ua_o) == (32'(pump_code) + 1) * PUMP_STEP_UA)
    else $error("pump current does not match weights");
  setting_hold_a: assert property (!load_strobe_i [*8] |-> $stable({reference_divide_ratio_o,
      detector_polarity_o, doubler_enable_o, dll_fast_o}))
    else $error("setting changed without a load strobe");
  n_pulse_a: assert property (n_load_o |=> !n_load_o)
    else $error("feedback load pulse longer than one cycle");
  n_only_a: assert property (n_load_o |=> $stable(reference_divide_ratio_o) [*3])
    else $error("feedback word changed the reference ratio");
endmodule // synth_checker
bind synth_serial_load_lock_power synth_checker i_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .load_strobe_i(load_strobe_i), .enable_i(enable_i), .power_down_bit_i(power_down_bit_i),
  .reference_divide_ratio_o(reference_divide_ratio_o), .detector_polarity_o(detector_polarity_o),
  .pump_weight_one_o(pump_weight_one_o), .pump_weight_two_o(pump_weight_two_o),
  .pump_weight_four_o(pump_weight_four_o), .pump_weight_eight_o(pump_weight_eight_o),
  .pump_current_ua_o(pump_current_ua_o), .doubler_enable_o(doubler_enable_o),
  .dll_fast_o(dll_fast_o), .counters_enable_o(counters_enable_o),
  .counter_reset_o(counter_reset_o), .pump_hiz_o(pump_hiz_o),
  .osc_input_enable_o(osc_input_enable_o), .n_load_o(n_load_o));
`default_nettype wire

// file: test/serial_host_model.sv
// host model: shifts one 24-bit word per request, then strobes it in
// assumes go_i is raised for one clock with word_i held until busy_o falls
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic clk_i, // system clock
  input wire logic go_i, // start one word
  input wire logic [23:0] word_i, // word to send
  output logic serial_clk_o, // serial clock, still between words
  output logic serial_data_o, // serial data
  output logic load_strobe_o, // load strobe
  output logic busy_o // word in progress
);
  int i;
  // idle levels
  initial begin
    serial_clk_o = 1'b0;
    serial_data_o = 1'b0;
    load_strobe_o = 1'b0;
    busy_o = 1'b0;
  end
  // 400 ns bit time; data moves as the clock falls, steady across the rise
  always begin
    @(posedge clk_i);
    #1;
    if (go_i) begin
      busy_o = 1'b1;
      for (i = 23; i >= 0; i--) begin
        serial_data_o = word_i[i];
        repeat (4) @(posedge clk_i);
        #1 serial_clk_o = 1'b1;
        repeat (4) @(posedge clk_i);
        #1 serial_clk_o = 1'b0;
      end
      repeat (4) @(posedge clk_i);
      #1 load_strobe_o = 1'b1;
      repeat (4) @(posedge clk_i);
      #1 load_strobe_o = 1'b0;
      busy_o = 1'b0;
    end else begin
      serial_data_o = ~serial_data_o; // idle data toggles each clock, no held value
    end
  end
endmodule // serial_host_model
`default_nettype wire

// file: test/tb_top.sv
// bench: host model loads words; expected values kept as plain integers
// assumes design, checker and host model compiled first; 50 ns clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import synth_pkg::*;
  logic clk_i, rst_b_i, enable_i, pd_bit, ref_div, fb_div, pump, sclk, sdata, strobe, go, busy;
  logic mf, aux0, aux0_oe, aux1, cnt_en, cnt_rst, hiz, osc, dbl, dll, pol, w1, w2, w4, w8, nld;
  logic [23:0] word;
  logic [14:0] ratio;
  logic [10:0] cur_ua;
  logic [21:0] ldata, d;
  logic [6:0] ctl;
  logic [2:0] sel;
  logic [31:0] seed_r;
  int miscompares, cmp_count, k, v, n_loads;
  // free-running system clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  serial_host_model i_host (.clk_i(clk_i), .go_i(go), .word_i(word), .serial_clk_o(sclk),
    .serial_data_o(sdata), .load_strobe_o(strobe), .busy_o(busy));
  synth_serial_load_lock_power i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .serial_clk_i(sclk),
    .serial_data_i(sdata), .load_strobe_i(strobe), .enable_i(enable_i),
    .power_down_bit_i(pd_bit), .ref_div_out_i(ref_div), .fb_div_out_i(fb_div),
    .pump_active_i(pump), .reference_divide_ratio_o(ratio), .detector_polarity_o(pol),
    .pump_weight_one_o(w1), .pump_weight_two_o(w2), .pump_weight_four_o(w4),
    .pump_weight_eight_o(w8), .pump_current_ua_o(cur_ua), .doubler_enable_o(dbl),
    .dll_fast_o(dll), .counters_enable_o(cnt_en), .counter_reset_o(cnt_rst), .pump_hiz_o(hiz),
    .osc_input_enable_o(osc), .multifunction_lock_output_o(mf), .aux_out0_o(aux0),
    .aux_out0_oe_o(aux0_oe), .aux_out1_o(aux1), .n_load_o(nld), .load_data_o(ldata));
  // feedback load pulses, counted away from the launching edge
  always @(negedge clk_i) begin
    if (nld === 1'b1) n_loads++;
  end
  // verdict and end of run
  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // n clock edges, then the usual drive offset
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one word through the host model; bounded wait for its end
  task automatic send(input logic [23:0] w);
    int n;
    word = w;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) miscompares++;
    tick(3);
  endtask
  // reference fields against the expected data field
  task automatic check_ref(input logic [21:0] e);
    check(32'(ratio), 32'(e[14:0]));
    check(32'({dll, dbl, w8, w4, w2, w1, pol}), 32'(e[21:15]));
    check(32'(cur_ua), 32'(e[19:16]) * 100 + 100);
  endtask
  // one comparison cycle with the pump busy for hi clocks
  task automatic cmp_cycle(input int hi);
    ref_div = 1'b1;
    pump = (hi != 0);
    tick(hi);
    pump = 1'b0;
    tick(6);
    ref_div = 1'b0;
    tick(8);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end
  initial begin
    {rst_b_i, enable_i, pd_bit, ref_div, fb_div, pump, go} = 7'h20;
    word = 24'h00_0000;
    miscompares = 0;
    cmp_count = 0;
    n_loads = 0;
    seed_r = $urandom(32'h1a32);
    tick(3);
    check(32'({cnt_rst, hiz, aux0_oe, cnt_en, mf}), 32'h0000_001c);
    tick(2);
    rst_b_i = 1'b1;
    tick(2);
    // boundary ratios and weights first, then random words
    for (k = 0; k < 6; k++) begin
      ctl = (k == 0) ? 7'h41 : (k == 1) ? 7'h5e : 7'($urandom);
      d = {ctl, (k == 0) ? 15'h0003 : (k == 1) ? 15'h7fff : 15'(3 + $urandom % 32765)};
      send({d, ADDR_REF});
      check_ref(d);
      check(32'(ldata), 32'(d));
    end
    send({22'h15_5555, ADDR_N});
    check_ref(d);
    check(32'(ldata), 32'h0015_5555);
    check(32'(n_loads), 32'h0000_0001);
    // pin power-down with doubler on, then a load while down
    d = {d[21], 1'b1, d[19:15], 15'h1234};
    send({d, ADDR_REF});
    enable_i = 1'b0;
    tick(6);
    check(32'({cnt_en, cnt_rst, hiz, osc, dbl}), 32'h0000_000f);
    d = {d[21], 1'b0, d[19:15], 15'h4321};
    send({d, ADDR_REF});
    check_ref(d);
    check(32'({cnt_en, cnt_rst, hiz, osc}), 32'h0000_0006);
    {enable_i, pd_bit} = 2'b11;
    tick(6);
    check(32'({cnt_en, cnt_rst, hiz, osc}), 32'h0000_0006);
    pd_bit = 1'b0;
    tick(6);
    check(32'({cnt_en, cnt_rst, hiz, osc}), 32'h0000_0009);
    // digital lock: four good cycles too few, six enough
    for (k = 0; k < 4; k++) cmp_cycle(0);
    check(32'(mf), 32'h0000_0000);
    for (k = 0; k < 2; k++) cmp_cycle(0);
    check(32'(mf), 32'h0000_0001);
    pd_bit = 1'b1;
    tick(6);
    check(32'(mf), 32'h0000_0000);
    pd_bit = 1'b0;
    for (k = 0; k < 6; k++) cmp_cycle(0);
    check(32'(mf), 32'h0000_0001);
    cmp_cycle(4);
    check(32'(mf), 32'h0000_0000);
    cmp_cycle(0);
    check(32'(mf), 32'h0000_0000);
    // other sources on the multifunction output
    for (k = 1; k < 4; k++) begin
      sel = 3'(k);
      send({(22'(sel) << F1_SEL_LSB), ADDR_F1});
      for (v = 0; v < 2; v++) begin
        {pump, ref_div, fb_div} = {3{v[0]}};
        tick(6);
        check(32'(mf), 32'(v[0] ^ (sel == SEL_ANALOG)));
      end
    end
    // lock is low here, so fast acquisition takes effect
    send({(22'(4'h4) << F2_MODE_LSB), ADDR_F2});
    check(32'({w8, w4, w2, w1, aux0_oe, aux0}), 32'h0000_003e);
    check(32'(cur_ua), 32'h0000_0640);
    send({(22'(4'h8) << F2_MODE_LSB), ADDR_F2});
    for (v = 0; v < 2; v++) begin
      {ref_div, fb_div} = {v[0], ~v[0]};
      tick(6);
      check(32'({aux0, aux1}), 32'({v[0], ~v[0]}));
    end
    send({(22'(4'h3) << F2_MODE_LSB), ADDR_F2});
    check(32'({aux0_oe, aux0, aux1}), 32'h0000_0007);
    check_ref(d);
    check(32'(n_loads), 32'h0000_0001);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
